/* File: rtl/ssci_image.sv */
// Command and response process image of a stepper positioning module
//
// The plain strobed port was decided locally.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - The sixteen-byte response image is readable at any time, always current.
// - Position, frequency, errors, mode, state, variable data at their byte offsets.
// - Error flags are sticky; a persisting cause sets the flag again.
// - Byte 9 flags state fault, boot, parameter check, refusal, block, position, switch, clamp.
// - Byte 8 bit 0 flags a general motor fault.
// - Mode 07h clears exactly the flags whose bits are one in the control word.
// - Several flags clear at once; all ones clears all but those whose cause is still present.
// - Byte 10 reports the active mode code 00h to 08h.
// - Byte 11 reports running, forward direction and target reached.
// - In mode 04h byte 15 returns switch A, switch B and home levels.
// - Start strobe launches the loaded mode, then the device clears it next cycle.
// - With strobe low no mode starts; the image is only refreshed.
// - Position setpoint is a target only in modes 01h, 06h and 08h.
// - Continuous run drives the motor at the frequency setpoint.
// - Reference run control: direction, clear position, home, switch B or switch A target.
module ssci_image (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   input wire logic limit_switch_a_in,
   input wire logic limit_switch_b_in,
   input wire logic home_switch_in,
   input wire ssci_pkg::ssci_drive_s drive_in,
   input wire ssci_pkg::ssci_fault_s fault_in,
   output ssci_pkg::ssci_cmd_s launch_out,
   output logic [31:0] target_position_out,
   output logic load_position_out,
   output logic [31:0] run_frequency_out,
   output logic ref_forward_out,
   output logic ref_clear_position_out,
   output logic [2:0] ref_target_out,
   output logic [7:0] current_mode_out
);
   import ssci_pkg::*;

   // ------------------------------------------------------------
   // Command registers
   // ------------------------------------------------------------
   logic [31:0] position_setpoint;
   logic [31:0] frequency_setpoint;
   ssci_mode_e command_mode;
   logic [15:0] control_word;
   logic start;
   logic start_taken;

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         position_setpoint <= 32'h0000_0000;
         frequency_setpoint <= 32'h0000_0000;
         command_mode <= SSCI_MODE_IDLE;
         control_word <= 16'h0000;
      end else if (wr_in) begin
         unique case (addr_in)
            ADDR_POSITION_SETPOINT: begin
               position_setpoint <= wdata_in;
            end
            ADDR_FREQUENCY_SETPOINT: begin
               frequency_setpoint <= wdata_in;
            end
            ADDR_COMMAND_MODE: begin
               // Codes above 08h are not modes; they fall back to idle
               if (wdata_in[7:0] <= MODE_CODE_LAST) begin
                  command_mode <= ssci_mode_e'(wdata_in[7:0]);
               end else begin
                  command_mode <= SSCI_MODE_IDLE;
               end
            end
            ADDR_CONTROL_WORD: begin
               control_word <= wdata_in[15:0];
            end
            default: begin
            end
         endcase
      end
   end

   // Strobe: set by the controller, taken and dropped by the device next cycle
   assign start_taken = start;
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         start <= 1'b0;
      end else if (wr_in && addr_in == ADDR_START) begin
         start <= wdata_in[0];
      end else if (start_taken) begin
         start <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Input synchronisers (three stages, change counted on agreement)
   // ------------------------------------------------------------
   logic [2:0] sw_s1;
   logic [2:0] sw_s2;
   logic [2:0] sw_s3;
   logic [2:0] switch_level;

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sw_s1 <= 3'h0;
         sw_s2 <= 3'h0;
         sw_s3 <= 3'h0;
      end else begin
         sw_s1 <= {home_switch_in, limit_switch_b_in, limit_switch_a_in};
         sw_s2 <= sw_s1;
         sw_s3 <= sw_s2;
      end
   end

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         switch_level <= 3'h0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (sw_s2[i] == sw_s3[i]) begin
               switch_level[i] <= sw_s3[i];
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Mode launch and the active mode
   // ------------------------------------------------------------
   ssci_mode_e active_mode;

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         active_mode <= SSCI_MODE_IDLE;
      end else if (start_taken) begin
         active_mode <= command_mode;
      end
      // With the strobe low the mode is held and nothing new starts
   end

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         launch_out <= '0;
         target_position_out <= 32'h0000_0000;
         load_position_out <= 1'b0;
         run_frequency_out <= 32'h0000_0000;
         ref_forward_out <= 1'b0;
         ref_clear_position_out <= 1'b0;
         ref_target_out <= 3'h0;
      end else begin
         launch_out <= '0;
         load_position_out <= 1'b0;
         if (start_taken) begin
            launch_out.start <= 1'b1;
            launch_out.mode <= command_mode;
            launch_out.position <= position_setpoint;
            launch_out.frequency <= frequency_setpoint;
            launch_out.control <= control_word;
            unique case (command_mode)
               SSCI_MODE_REL_POS, SSCI_MODE_ABS_POS: begin
                  target_position_out <= position_setpoint;
               end
               SSCI_MODE_SET_POS: begin
                  target_position_out <= position_setpoint;
                  load_position_out <= 1'b1;
               end
               SSCI_MODE_CONT_RUN: begin
                  run_frequency_out <= frequency_setpoint;
               end
               SSCI_MODE_REF_RUN: begin
                  // Target bits pass unchecked; the controller sets one at most
                  ref_forward_out <= control_word[CW_FORWARD];
                  ref_clear_position_out <= control_word[CW_CLEAR_POS];
                  ref_target_out <= {control_word[CW_TO_SWITCH_A],
                                     control_word[CW_TO_SWITCH_B],
                                     control_word[CW_TO_HOME]};
               end
               default: begin
               end
            endcase
         end
      end
   end

   assign current_mode_out = active_mode;

   // ------------------------------------------------------------
   // Sticky error flags
   // ------------------------------------------------------------
   logic [15:0] error_flags;
   logic [15:0] error_cause;
   logic [15:0] error_clear;

   always_comb begin
      error_cause = 16'h0000;
      error_cause[ERR_MOTOR_FAULT] = fault_in.motor_fault;
      error_cause[ERR_STATE_FAULT] = fault_in.state_fault;
      error_cause[ERR_PARAM_CHECK] = fault_in.param_check;
      error_cause[ERR_REFUSED_RUN] = fault_in.refused_run;
      error_cause[ERR_BLOCKED] = fault_in.blocked;
      error_cause[ERR_POSITIONING] = fault_in.positioning;
      error_cause[ERR_END_SWITCH] = fault_in.end_switch | switch_level[IN_SWITCH_A]
                                    | switch_level[IN_SWITCH_B];
      error_cause[ERR_FREQ_CLAMP] = fault_in.freq_clamp;
   end

   // Clear acts in the cycle the clear-errors mode is launched
   assign error_clear = (start_taken && command_mode == SSCI_MODE_CLR_ERR) ?
                        control_word : 16'h0000;

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         error_flags <= ERR_RESET; // booted flag after every power-up
      end else begin
         // A cause present in the clearing cycle wins
         error_flags <= ((error_flags & ~error_clear) | error_cause) & ERR_DEFINED_MASK;
      end
   end

   // ------------------------------------------------------------
   // Response image read port
   // ------------------------------------------------------------
   logic [7:0] drive_state;
   logic [31:0] variable_data;

   always_comb begin
      drive_state = 8'h00;
      drive_state[ST_RUNNING] = drive_in.running;
      drive_state[ST_FORWARD] = drive_in.forward;
      drive_state[ST_IN_POSITION] = drive_in.in_position;
      variable_data = 32'h0000_0000;
      if (active_mode == SSCI_MODE_READ_IN) begin
         // Byte 15 is the high byte of the word at offset 0ch
         variable_data[VAR_INPUTS_LSB + IN_SWITCH_A] = switch_level[IN_SWITCH_A];
         variable_data[VAR_INPUTS_LSB + IN_SWITCH_B] = switch_level[IN_SWITCH_B];
         variable_data[VAR_INPUTS_LSB + IN_HOME] = switch_level[IN_HOME];
      end
   end

   // Bytes 8..11 share one word: errors low half, mode, then state
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rdata_out <= 32'h0000_0000;
      end else if (rd_in) begin
         unique case (addr_in)
            ADDR_ACTUAL_POSITION: begin
               rdata_out <= drive_in.position;
            end
            ADDR_ACTUAL_FREQUENCY: begin
               rdata_out <= drive_in.frequency;
            end
            ADDR_ERROR_FLAGS: begin
               rdata_out <= {drive_state, active_mode, error_flags};
            end
            // Single-byte views of the mode and state bytes, zero-extended
            ADDR_CURRENT_MODE: begin
               rdata_out <= {24'h000000, active_mode};
            end
            ADDR_DRIVE_STATE: begin
               rdata_out <= {24'h000000, drive_state};
            end
            ADDR_VARIABLE_DATA: begin
               rdata_out <= variable_data;
            end
            ADDR_POSITION_SETPOINT: begin
               rdata_out <= position_setpoint;
            end
            ADDR_FREQUENCY_SETPOINT: begin
               rdata_out <= frequency_setpoint;
            end
            ADDR_COMMAND_MODE: begin
               rdata_out <= {24'h000000, command_mode};
            end
            ADDR_CONTROL_WORD: begin
               rdata_out <= {16'h0000, control_word};
            end
            ADDR_START: begin
               rdata_out <= {31'h0000_0000, start};
            end
            default: begin
               rdata_out <= 32'h0000_0000;
            end
         endcase
      end else begin
         rdata_out <= 32'h0000_0000;
      end
   end

endmodule
`default_nettype wire

/* File: rtl/ssci_pkg.sv */
// Package: offsets, field positions, mode codes and carriers of the stepper command image
package ssci_pkg;

   // ------------------------------------------------------------
   // Register map (byte addresses of the 16-byte response image)
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_ACTUAL_POSITION = 8'h00;
   localparam logic [7:0] ADDR_ACTUAL_FREQUENCY = 8'h04;
   localparam logic [7:0] ADDR_ERROR_FLAGS = 8'h08;
   localparam logic [7:0] ADDR_CURRENT_MODE = 8'h0a;
   localparam logic [7:0] ADDR_DRIVE_STATE = 8'h0b;
   localparam logic [7:0] ADDR_VARIABLE_DATA = 8'h0c;
   // Command registers written by the controller
   localparam logic [7:0] ADDR_POSITION_SETPOINT = 8'h10;
   localparam logic [7:0] ADDR_FREQUENCY_SETPOINT = 8'h14;
   localparam logic [7:0] ADDR_COMMAND_MODE = 8'h18;
   localparam logic [7:0] ADDR_CONTROL_WORD = 8'h1c;
   localparam logic [7:0] ADDR_START = 8'h20;
   // Highest legal mode code; anything above is stored as idle
   localparam logic [7:0] MODE_CODE_LAST = 8'h08;
   // Image byte 15 is the high byte of the variable-data word
   localparam int VAR_INPUTS_LSB = 24;

   // ------------------------------------------------------------
   // Mode codes
   // ------------------------------------------------------------
   typedef enum logic [7:0] {
      SSCI_MODE_IDLE = 8'h00,
      SSCI_MODE_REL_POS = 8'h01,
      SSCI_MODE_REF_RUN = 8'h02,
      SSCI_MODE_CONT_RUN = 8'h03,
      SSCI_MODE_READ_IN = 8'h04,
      SSCI_MODE_MOTOR_PAR = 8'h05,
      SSCI_MODE_SET_POS = 8'h06,
      SSCI_MODE_CLR_ERR = 8'h07,
      SSCI_MODE_ABS_POS = 8'h08
   } ssci_mode_e;

   // ------------------------------------------------------------
   // Error flag positions (16-bit word: high byte is image byte 9)
   // ------------------------------------------------------------
   localparam int ERR_MOTOR_FAULT = 0;
   localparam int ERR_STATE_FAULT = 8;
   localparam int ERR_BOOTED = 9;
   localparam int ERR_PARAM_CHECK = 10;
   localparam int ERR_REFUSED_RUN = 11;
   localparam int ERR_BLOCKED = 12;
   localparam int ERR_POSITIONING = 13;
   localparam int ERR_END_SWITCH = 14;
   localparam int ERR_FREQ_CLAMP = 15;
   localparam logic [15:0] ERR_DEFINED_MASK = 16'hff01;
   localparam logic [15:0] ERR_RESET = 16'h0200;

   // Drive state bits, control word bits, input bits
   localparam int ST_RUNNING = 0;
   localparam int ST_FORWARD = 1;
   localparam int ST_IN_POSITION = 2;
   localparam int CW_FORWARD = 0;
   localparam int CW_CLEAR_POS = 1;
   localparam int CW_TO_HOME = 2;
   localparam int CW_TO_SWITCH_B = 3;
   localparam int CW_TO_SWITCH_A = 4;
   localparam int IN_SWITCH_A = 0;
   localparam int IN_SWITCH_B = 1;
   localparam int IN_HOME = 2;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic motor_fault;
      logic state_fault;
      logic param_check;
      logic refused_run;
      logic blocked;
      logic positioning;
      logic end_switch;
      logic freq_clamp;
   } ssci_fault_s;

   typedef struct packed {
      logic running;
      logic forward;
      logic in_position;
      logic [31:0] position;
      logic [31:0] frequency;
   } ssci_drive_s;

   typedef struct packed {
      logic start;
      ssci_mode_e mode;
      logic [31:0] position;
      logic [31:0] frequency;
      logic [15:0] control;
   } ssci_cmd_s;

endpackage

/* File: dv/ssci_image_asserts.sv */
// Checker: port-level properties of the stepper command image
`timescale 1ns/100ps
`default_nettype none
module ssci_image_asserts import ssci_pkg::*; (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [31:0] rdata_out,
   input wire ssci_pkg::ssci_drive_s drive_in,
   input wire ssci_pkg::ssci_cmd_s launch_out,
   input wire logic load_position_out,
   input wire logic [7:0] current_mode_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);
   // ------------------------------------------------------------
   // Launch handshake
   // ------------------------------------------------------------
   sequence s_start_written;
      wr_in && addr_in == ADDR_START && wdata_in[0];
   endsequence
   sequence s_one_launch;
      ##2 launch_out.start ##1 !launch_out.start;
   endsequence
   chk_start_launch: assert property (s_start_written |-> s_one_launch)
      else $error("start write not followed by a single launch pulse");
   chk_quiet_launch: assert property (!launch_out.start |-> launch_out == '0)
      else $error("launch fields set outside a launch");
   chk_mode_on_launch: assert property (launch_out.start |-> current_mode_out == launch_out.mode)
      else $error("active mode differs from launched mode");
   chk_mode_cause: assert property ($changed(current_mode_out) |-> launch_out.start)
      else $error("active mode changed without a launch");
   chk_mode_range: assert property (current_mode_out <= 8'h08)
      else $error("active mode outside the defined codes");
   chk_load_set_pos: assert property (load_position_out ==
         (launch_out.start && launch_out.mode == SSCI_MODE_SET_POS))
      else $error("position load pulse without set-position launch");
   // ------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------
   chk_rdata_idle: assert property (!rd_in |=> rdata_out == 32'h0)
      else $error("read data not zero outside a read answer");
   chk_read_pos: assert property (rd_in && addr_in == ADDR_ACTUAL_POSITION
         |=> rdata_out == $past(drive_in.position))
      else $error("position read differs from actual position");
   chk_read_word: assert property (rd_in && addr_in == ADDR_ERROR_FLAGS
         |=> rdata_out[23:16] == $past(current_mode_out) && rdata_out[7:1] == 7'h0
         && rdata_out[31:27] == 5'h0)
      else $error("status word read wrong mode or undefined bits");
endmodule
bind ssci_image ssci_image_asserts ssci_image_asserts_i (.mclk_in(mclk_in),
   .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
   .rd_in(rd_in), .rdata_out(rdata_out), .drive_in(drive_in), .launch_out(launch_out),
   .load_position_out(load_position_out), .current_mode_out(current_mode_out));
`default_nettype wire

/* File: dv/ssci_cpu_model.sv */
// Controller model: register-bus master that loads setpoints and starts modes
`timescale 1ns/100ps
`default_nettype none
module ssci_cpu_model import ssci_pkg::*; (
   input wire logic mclk_in,
   input wire logic [31:0] rdata_in,
   output logic [7:0] addr_out,
   output logic [31:0] wdata_out,
   output logic wr_out,
   output logic rd_out
);
   initial begin
      addr_out = 8'h00;
      wdata_out = 32'h0;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge mclk_in);
      wr_out <= 1'b0;
   endtask
   // Data stand only in the cycle after the read edge, so sample just past it
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk_in);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge mclk_in);
      rd_out <= 1'b0;
      #1;
      d = rdata_in;
   endtask
   // Start goes last: the device launches whatever is loaded at that moment
   task automatic start_mode(input logic [7:0] m, input logic [31:0] p, input logic [31:0] f,
         input logic [15:0] c);
      if (m == SSCI_MODE_REF_RUN && !$onehot0(c[4:2])) c = 16'h0005;
      wr_reg(ADDR_POSITION_SETPOINT, p);
      wr_reg(ADDR_FREQUENCY_SETPOINT, f);
      wr_reg(ADDR_CONTROL_WORD, {16'h0, c});
      wr_reg(ADDR_COMMAND_MODE, {24'h0, m});
      wr_reg(ADDR_START, 32'h1);
   endtask
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// Testbench: register-level tests of the stepper command image
`timescale 1ns/100ps
`default_nettype none
module tb;
   import ssci_pkg::*;
   logic mclk_in, resetn_in, wr_in, rd_in, ref_forward_out, ref_clear_position_out;
   logic limit_switch_a_in, limit_switch_b_in, home_switch_in;
   logic [7:0] addr_in, current_mode_out;
   logic [31:0] wdata_in, rdata_out, target_position_out, run_frequency_out, exp_tgt, exp_freq;
   logic [2:0] ref_target_out;
   ssci_drive_s drive_in;
   ssci_fault_s fault_in;
   ssci_cmd_s launch_out, last_launch;
   int n_mismatch, total_checks;
   ssci_image ssci_image_i (.mclk_in(mclk_in), .resetn_in(resetn_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .limit_switch_a_in(limit_switch_a_in), .limit_switch_b_in(limit_switch_b_in),
      .home_switch_in(home_switch_in), .drive_in(drive_in), .fault_in(fault_in),
      .launch_out(launch_out), .target_position_out(target_position_out), .load_position_out(),
      .run_frequency_out(run_frequency_out), .ref_forward_out(ref_forward_out),
      .ref_clear_position_out(ref_clear_position_out), .ref_target_out(ref_target_out),
      .current_mode_out(current_mode_out));
   ssci_cpu_model ssci_cpu_model_i (.mclk_in(mclk_in), .rdata_in(rdata_out),
      .addr_out(addr_in), .wdata_out(wdata_in), .wr_out(wr_in), .rd_out(rd_in));
   // The launch pulse stands one cycle only, so keep its fields for a later compare
   always_ff @(posedge mclk_in) begin
      if (launch_out.start) begin
         last_launch <= launch_out;
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      ssci_cpu_model_i.rd_reg(a, d);
      check(d, exp);
   endtask
   task automatic err_check(input logic [15:0] e);
      logic [31:0] d;
      ssci_cpu_model_i.rd_reg(ADDR_ERROR_FLAGS, d);
      check({16'h0, d[15:0]}, {16'h0, e});
   endtask
   task automatic clear_errors(input logic [15:0] mask);
      ssci_cpu_model_i.start_mode(SSCI_MODE_CLR_ERR, 32'h0, 32'h0, mask);
      repeat (4) @(posedge mclk_in);
   endtask
   task automatic summarize();
      $display("mismatches %0d checks %0d", n_mismatch, total_checks);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end
   // Whole sequence needs well under 2000 cycles
   initial begin
      repeat (20000) @(posedge mclk_in);
      n_mismatch++;
      summarize();
   end
   initial begin
      resetn_in = 1'b0;
      limit_switch_a_in = 1'b0;
      limit_switch_b_in = 1'b0;
      home_switch_in = 1'b0;
      drive_in = '0;
      fault_in = '0;
      n_mismatch = 0;
      total_checks = 0;
      exp_tgt = 32'h0;
      exp_freq = 32'h0;
      repeat (20) @(posedge mclk_in);
      resetn_in <= 1'b1;
      err_check(16'h0200);
      rd_check(8'h30, 32'h0);
      @(posedge mclk_in);
      drive_in <= '{1'b1, 1'b1, 1'b0, 32'h8765_4321, 32'h0000_0abc};
      rd_check(ADDR_ACTUAL_POSITION, 32'h8765_4321);
      rd_check(ADDR_ACTUAL_FREQUENCY, 32'h0000_0abc);
      rd_check(ADDR_ERROR_FLAGS, 32'h0300_0200);
      rd_check(ADDR_DRIVE_STATE, 32'h0000_0003);
      @(posedge mclk_in);
      fault_in <= '1;
      @(posedge mclk_in);
      fault_in <= '0;
      err_check(16'hff01);
      clear_errors(16'h1201);
      err_check(16'hed00);
      @(posedge mclk_in);
      fault_in.positioning <= 1'b1;
      clear_errors(16'hffff);
      err_check(16'h2000);
      @(posedge mclk_in);
      fault_in.positioning <= 1'b0;
      clear_errors(16'hffff);
      err_check(16'h0000);
      for (int m = 0; m <= 8; m++) begin
         ssci_cpu_model_i.start_mode(m[7:0], 32'h100 + m, 32'h200 + m, 16'h0013);
         if (m == 1 || m == 6 || m == 8) exp_tgt = 32'(32'h100 + m);
         if (m == 3) exp_freq = 32'(32'h200 + m);
         repeat (4) @(posedge mclk_in);
         rd_check(ADDR_START, 32'h0);
         rd_check(ADDR_CURRENT_MODE, 32'(m));
         check({24'h0, current_mode_out}, 32'(m));
         check({24'h0, last_launch.mode}, 32'(m));
         check(last_launch.position, 32'(32'h100 + m));
         check(last_launch.frequency, 32'(32'h200 + m));
         check({16'h0, last_launch.control}, 32'h13);
         check(target_position_out, exp_tgt);
         check(run_frequency_out, exp_freq);
      end
      check({27'h0, ref_forward_out, ref_clear_position_out, ref_target_out}, 32'h1c);
      @(posedge mclk_in);
      limit_switch_a_in <= 1'b1;
      home_switch_in <= 1'b1;
      repeat (6) @(posedge mclk_in);
      ssci_cpu_model_i.start_mode(SSCI_MODE_READ_IN, 32'h0, 32'h0, 16'h0);
      repeat (4) @(posedge mclk_in);
      rd_check(ADDR_VARIABLE_DATA, 32'h0500_0000);
      err_check(16'h4000);
      ssci_cpu_model_i.start_mode(SSCI_MODE_IDLE, 32'h0, 32'h0, 16'h0);
      repeat (4) @(posedge mclk_in);
      rd_check(ADDR_VARIABLE_DATA, 32'h0);
      ssci_cpu_model_i.wr_reg(ADDR_COMMAND_MODE, 32'h0000_0009);
      rd_check(ADDR_COMMAND_MODE, 32'h0);
      @(posedge mclk_in);
      limit_switch_a_in <= 1'b0;
      home_switch_in <= 1'b0;
      repeat (6) @(posedge mclk_in);
      err_check(16'h4000);
      // Mid-run reset: only the booted flag comes back
      @(posedge mclk_in);
      resetn_in <= 1'b0;
      repeat (3) @(posedge mclk_in);
      resetn_in <= 1'b1;
      err_check(16'h0200);
      check({24'h0, current_mode_out}, 32'h0);
      check(target_position_out, 32'h0);
      summarize();
   end
endmodule
`default_nettype wire
